// *** hdl/watchdog_timer_unit.sv ***
/*
 * watchdog timer unit: prescaler, postscaler, power-state tracking,
 * reset-control/status register and an avalon-mm slave.
 * assumes low_power_rc_clock and all strobes are synchronous to clk_sys,
 * and that the chip feeds timeout_reset back as a device_reset pulse.
 */
`timescale 1ns/100ps
`default_nettype none

module watchdog_timer_unit (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// configuration fuses
	input  wire logic        hard_enable_fuse,
	input  wire logic        prescale_ratio_select,
	input  wire logic [3:0]  postscale_select,
	// cpu and clock events
	input  wire logic        low_power_rc_clock,
	input  wire logic        device_reset,
	input  wire logic        clock_switch_done,
	input  wire logic        power_save_instruction,
	input  wire logic        power_save_idle,
	input  wire logic        clear_watchdog_instruction,
	input  wire logic        wake_event,
	// results
	output logic             rc_clock_enable,
	output logic             watchdog_running,
	output logic             timeout_reset,
	output logic             wake_request,
	output logic             power_sleep,
	output logic             power_idle
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic                                  rc_q;
	logic                                  rc_prev_q;
	logic                                  rc_tick;
	logic                                  soft_en_q;
	logic                                  timeout_flag_q;
	logic                                  sleep_bit_q;
	logic                                  idle_bit_q;
	logic                                  enabled;
	watchdog_pkg::power_state_t            pwr_q;
	watchdog_pkg::power_state_t            pwr_d;
	logic                                  in_run;
	logic                                  enter_save;
	logic                                  enter_sleep;
	logic                                  enter_idle;
	logic                                  leave_save;
	logic                                  clear_all;
	logic                                  clear_by_reset;
	logic                                  clear_by_switch;
	logic                                  clear_by_power;
	logic                                  clear_by_instr;
	logic                                  clear_base;
	logic                                  timeout_hit;
	logic [watchdog_pkg::PRE_W-1:0]        pre_q;
	logic [watchdog_pkg::PRE_W-1:0]        pre_term;
	logic                                  pre_done;
	logic [watchdog_pkg::POST_W-1:0]       post_q;
	logic [watchdog_pkg::POST_W-1:0]       post_term;
	logic                                  timeout;
	logic                                  timeout_reset_q;
	logic                                  wake_q;
	logic                                  ack_q;
	logic [31:0]                           readdata_q;
	logic [31:0]                           read_word;
	logic                                  wr_take;
	logic                                  wr_ctrl;
	logic                                  clr_flag_wr;
	logic                                  clr_sleep_wr;
	logic                                  clr_idle_wr;

	// ****************************************************************
	// enable and rc clock
	// ****************************************************************
	assign enabled          = hard_enable_fuse | soft_en_q;
	assign rc_clock_enable  = enabled;
	assign watchdog_running = enabled;

	// sample the rc clock
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rc_q <= 1'b0;
		end else begin
			rc_q <= low_power_rc_clock;
		end
	end

	// previous sample, for edge detection
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rc_prev_q <= 1'b0;
		end else begin
			rc_prev_q <= rc_q;
		end
	end

	// rising edge of the rc clock, one clk_sys cycle wide
	assign rc_tick = rc_q & ~rc_prev_q;

	// ****************************************************************
	// power state
	// ****************************************************************
	assign in_run     = (pwr_q == watchdog_pkg::PWR_RUN);
	assign enter_save = in_run & power_save_instruction;
	assign enter_sleep = enter_save & ~power_save_idle;
	assign enter_idle  = enter_save & power_save_idle;
	assign leave_save = ~in_run & (wake_event | timeout);

	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			watchdog_pkg::PWR_RUN: begin
				if (power_save_instruction) begin
					pwr_d = power_save_idle ? watchdog_pkg::PWR_IDLE
					                        : watchdog_pkg::PWR_SLEEP;
				end
			end
			watchdog_pkg::PWR_SLEEP,
			watchdog_pkg::PWR_IDLE: begin
				if (wake_event || timeout) begin
					pwr_d = watchdog_pkg::PWR_RUN;
				end
			end
			default: begin
				pwr_d = watchdog_pkg::PWR_RUN;
			end
		endcase
		if (device_reset) begin
			pwr_d = watchdog_pkg::PWR_RUN;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pwr_q <= watchdog_pkg::PWR_RUN;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	assign power_sleep = (pwr_q == watchdog_pkg::PWR_SLEEP);
	assign power_idle  = (pwr_q == watchdog_pkg::PWR_IDLE);

	// ****************************************************************
	// clearing of counter, prescaler and postscaler
	// ****************************************************************
	assign clear_by_reset  = device_reset;
	assign clear_by_switch = clock_switch_done;
	assign clear_by_power  = enter_save | (~in_run & wake_event);
	assign clear_by_instr  = in_run & clear_watchdog_instruction;
	// a timeout that ends sleep or idle must not be masked by its own wake clear
	assign clear_base = clear_by_reset
	                  | clear_by_switch
	                  | clear_by_power
	                  | clear_by_instr
	                  | ~enabled;
	assign clear_all  = clear_base | leave_save;

	// ****************************************************************
	// prescaler
	// ****************************************************************
	assign pre_term = prescale_ratio_select ? watchdog_pkg::PRE_TERM_LONG
	                                        : watchdog_pkg::PRE_TERM_SHORT;
	assign pre_done = rc_tick & (pre_q == pre_term);

	// counts on in sleep and idle as well as in run
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pre_q <= watchdog_pkg::PRE_ZERO;
		end else if (clear_all) begin
			pre_q <= watchdog_pkg::PRE_ZERO;
		end else if (pre_done) begin
			pre_q <= watchdog_pkg::PRE_ZERO;
		end else if (rc_tick) begin
			pre_q <= pre_q + 7'h01;
		end
	end

	// ****************************************************************
	// postscaler and timeout
	// ****************************************************************
	assign post_term = watchdog_pkg::POST_W'((watchdog_pkg::POST_ONE << postscale_select)
	                   - watchdog_pkg::POST_ONE);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			post_q <= watchdog_pkg::POST_ZERO;
		end else if (clear_all) begin
			post_q <= watchdog_pkg::POST_ZERO;
		end else if (pre_done) begin
			if (post_q == post_term) begin
				post_q <= watchdog_pkg::POST_ZERO;
			end else begin
				post_q <= post_q + 15'h0001;
			end
		end
	end

	// ****************************************************************
	// timeout detection
	// ****************************************************************
	// clear events win over a timeout in the same cycle
	assign timeout_hit = enabled & pre_done & (post_q == post_term);
	assign timeout     = timeout_hit & ~clear_base;

	// ****************************************************************
	// timeout effects
	// ****************************************************************
	// reset request for a timeout in run
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			timeout_reset_q <= 1'b0;
		end else begin
			timeout_reset_q <= timeout & in_run;
		end
	end

	// wake request for a timeout in sleep or idle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= timeout & ~in_run;
		end
	end

	assign timeout_reset = timeout_reset_q;
	assign wake_request  = wake_q;

	// ****************************************************************
	// avalon-mm slave
	// ****************************************************************
	// one wait cycle per access; the access completes on the second edge
	assign waitrequest = (read | write) & ~ack_q;
	assign wr_take     = write & ack_q;
	assign wr_ctrl     = wr_take & byteenable[0] & (address == watchdog_pkg::OFS_RST_CTRL);

	// strobes that clear status bits when a zero is written
	assign clr_flag_wr  = wr_ctrl & ~writedata[watchdog_pkg::BIT_TIMEOUT];
	assign clr_sleep_wr = wr_ctrl & ~writedata[watchdog_pkg::BIT_SLEEP];
	assign clr_idle_wr  = wr_ctrl & ~writedata[watchdog_pkg::BIT_IDLE];
	assign readdata    = readdata_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read | write) & ~ack_q;
		end
	end

	// read word for the addressed register
	always_comb begin
		read_word = watchdog_pkg::RDATA_ZERO;
		case (address)
			watchdog_pkg::OFS_RST_CTRL: begin
				read_word[watchdog_pkg::BIT_SOFT_EN] = soft_en_q;
				read_word[watchdog_pkg::BIT_TIMEOUT] = timeout_flag_q;
				read_word[watchdog_pkg::BIT_SLEEP]   = sleep_bit_q;
				read_word[watchdog_pkg::BIT_IDLE]    = idle_bit_q;
			end
			watchdog_pkg::OFS_COUNT: begin
				read_word[watchdog_pkg::CNT_POST_LSB +: watchdog_pkg::POST_W] = post_q;
				read_word[watchdog_pkg::CNT_PRE_LSB +: watchdog_pkg::PRE_W]   = pre_q;
			end
			default: begin
				read_word = watchdog_pkg::RDATA_ZERO;
			end
		endcase
	end

	// captured on the first cycle of a read, held until the next read
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			readdata_q <= watchdog_pkg::RDATA_ZERO;
		end else if (read && !ack_q) begin
			readdata_q <= read_word;
		end
	end

	// ****************************************************************
	// reset control and status bits
	// ****************************************************************
	// soft enable: read/write, cleared by every device reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			soft_en_q <= 1'b0;
		end else if (device_reset) begin
			soft_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			soft_en_q <= writedata[watchdog_pkg::BIT_SOFT_EN];
		end
	end

	// timeout flag: survives device reset, cleared only by writing zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			timeout_flag_q <= 1'b0;
		end else if (timeout) begin
			timeout_flag_q <= 1'b1;
		end else if (clr_flag_wr) begin
			timeout_flag_q <= 1'b0;
		end
	end

	// sleep bit: set on entry to sleep, left set on wake, cleared by writing zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sleep_bit_q <= 1'b0;
		end else if (enter_sleep) begin
			sleep_bit_q <= 1'b1;
		end else if (clr_sleep_wr) begin
			sleep_bit_q <= 1'b0;
		end
	end

	// idle bit: set on entry to idle, left set on wake, cleared by writing zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			idle_bit_q <= 1'b0;
		end else if (enter_idle) begin
			idle_bit_q <= 1'b1;
		end else if (clr_idle_wr) begin
			idle_bit_q <= 1'b0;
		end
	end

endmodule : watchdog_timer_unit

`default_nettype wire

// *** hdl/watchdog_pkg.sv ***
/*
 * constants for the watchdog timer unit: register offsets, field positions,
 * counter widths and divider terminals, power states.
 * assumes a 32-bit avalon-mm register bus with byte addresses.
 */
// What this block does
// - watchdog counts only low-power rc clock ticks; enabling it turns that clock on
// - prescaler divides the nominal 32 khz clock by 32 or by 128
// - prescaler period is about 1 ms at divide-by-32, 4 ms at divide-by-128
// - postscaler divides prescaler output by one of sixteen ratios up to 32768
// - device reset or finished clock switch clears counter, prescaler and postscaler
// - entering sleep or idle clears all counts, and leaving them clears again
// - clear-watchdog instruction in normal run clears counter, prescaler and postscaler
// - an enabled watchdog keeps counting during sleep and idle
// - timeout in sleep or idle wakes the device without a reset
// - timeout sets a sticky flag that only software clears
// - hard-enable fuse set keeps the watchdog running, software cannot stop it
// - with hard-enable fuse zero, watchdog runs only while soft enable bit set
// - every device reset clears the soft enable bit
// - prescale select one gives 1:128, zero gives 1:32
// - postscale field n gives a ratio of two to the power n
package watchdog_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int unsigned ADDR_W         = 4;
	localparam logic [3:0]  OFS_RST_CTRL   = 4'h0;
	localparam logic [3:0]  OFS_COUNT      = 4'h4;
	localparam int unsigned BIT_SOFT_EN    = 5;
	localparam int unsigned BIT_TIMEOUT    = 4;
	localparam int unsigned BIT_SLEEP      = 3;
	localparam int unsigned BIT_IDLE       = 2;
	localparam int unsigned CNT_POST_LSB   = 0;
	localparam int unsigned CNT_PRE_LSB    = 16;
	localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

	// ****************************************************************
	// timing of the prescaler in low-power rc clock ticks
	// ****************************************************************
	localparam int unsigned RC_CLOCK_HZ     = 32000;
	localparam int unsigned PERIOD_SHORT_US = 1000;
	localparam int unsigned PERIOD_LONG_US  = 4000;
	localparam int unsigned PRE_DIV_SHORT  = PERIOD_SHORT_US * RC_CLOCK_HZ / 1000000;
	localparam int unsigned PRE_DIV_LONG   = PERIOD_LONG_US * RC_CLOCK_HZ / 1000000;
	localparam int unsigned PRE_W          = 7;
	localparam logic [PRE_W-1:0] PRE_TERM_SHORT = PRE_W'(PRE_DIV_SHORT - 1);
	localparam logic [PRE_W-1:0] PRE_TERM_LONG  = PRE_W'(PRE_DIV_LONG - 1);
	localparam logic [PRE_W-1:0] PRE_ZERO       = 7'h00;

	// ****************************************************************
	// postscaler
	// ****************************************************************
	localparam int unsigned PS_SEL_W       = 4;
	localparam int unsigned POST_W         = 15;
	localparam logic [POST_W-1:0] POST_ZERO = 15'h0000;
	localparam logic [POST_W:0]   POST_ONE  = 16'h0001;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_SLEEP,
		PWR_IDLE
	} power_state_t;

endpackage : watchdog_pkg

// *** test/watchdog_timer_unit_asserts.sv ***
/*
 * checker for the watchdog timer unit: enable, timeout pulses, power states, bus wait.
 * assumes it is bound to watchdog_timer_unit and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module watchdog_timer_unit_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic hard_enable_fuse,
	input wire logic device_reset,
	input wire logic clock_switch_done,
	input wire logic power_save_instruction,
	input wire logic power_save_idle,
	input wire logic clear_watchdog_instruction,
	input wire logic wake_event,
	input wire logic rc_clock_enable,
	input wire logic watchdog_running,
	input wire logic timeout_reset,
	input wire logic wake_request,
	input wire logic power_sleep,
	input wire logic power_idle
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic in_run = !power_sleep && !power_idle;
	a_fuse_forces_on: assert property (hard_enable_fuse |-> rc_clock_enable)
		else $error("fuse set but watchdog off");
	a_running_clock_on: assert property (watchdog_running == rc_clock_enable)
		else $error("running without rc clock");
	a_disabled_silent: assert property (!rc_clock_enable [*3] |=> !(timeout_reset || wake_request))
		else $error("timeout while disabled");
	a_reset_only_run: assert property (timeout_reset |-> $past(in_run))
		else $error("reset pulse outside run");
	a_wake_only_low: assert property (wake_request |-> $past(!in_run) && !timeout_reset)
		else $error("wake pulse outside sleep or idle");
	a_enter_low_power: assert property (power_save_instruction && in_run && !device_reset
		&& !wake_event |=> power_idle == $past(power_save_idle) && power_sleep != power_idle)
		else $error("power state not entered");
	a_clear_quiet: assert property (clear_watchdog_instruction && in_run
		|=> (!timeout_reset) [*8])
		else $error("timeout right after clear");
	a_reset_quiet: assert property (device_reset || clock_switch_done
		|=> (!timeout_reset && !wake_request) [*8])
		else $error("timeout right after reset or switch");
	a_soft_cleared: assert property (device_reset && !hard_enable_fuse && !write
		|=> !rc_clock_enable)
		else $error("soft enable kept over device reset");
	a_bus_one_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus wait not one cycle");
endmodule : watchdog_timer_unit_asserts

bind watchdog_timer_unit watchdog_timer_unit_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.read(read), .write(write), .waitrequest(waitrequest), .hard_enable_fuse(hard_enable_fuse),
	.device_reset(device_reset), .clock_switch_done(clock_switch_done),
	.power_save_instruction(power_save_instruction), .power_save_idle(power_save_idle),
	.clear_watchdog_instruction(clear_watchdog_instruction), .wake_event(wake_event),
	.rc_clock_enable(rc_clock_enable), .watchdog_running(watchdog_running),
	.timeout_reset(timeout_reset), .wake_request(wake_request), .power_sleep(power_sleep),
	.power_idle(power_idle));

`default_nettype wire

// *** test/watchdog_timer_unit_tb.sv ***
/*
 * self-checking bench for the watchdog timer unit over its avalon-mm port.
 * assumes the rc clock is far slower than clk_sys; the bench makes it by hand.
 */
`timescale 1ns/100ps
`default_nettype none

module watchdog_timer_unit_tb;
	// ****************************************************************
	// stimulus and checks
	// ****************************************************************
	logic        clk_sys, rst_n, read, write, fuse, psel, rc, idle_sel;
	logic [3:0]  address, post;
	logic [31:0] writedata, readdata, q;
	logic [4:0]  evs;
	logic        waitrequest, rc_clock_enable, timeout_reset, wake_request, power_sleep, power_idle;
	int          bad_count, comparisons, rst_cnt, wake_cnt;

	watchdog_timer_unit u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
		.readdata(readdata), .waitrequest(waitrequest), .hard_enable_fuse(fuse),
		.prescale_ratio_select(psel), .postscale_select(post), .low_power_rc_clock(rc),
		.device_reset(evs[0]), .clock_switch_done(evs[1]), .power_save_instruction(evs[2]),
		.power_save_idle(idle_sel), .clear_watchdog_instruction(evs[3]), .wake_event(evs[4]),
		.rc_clock_enable(rc_clock_enable), .watchdog_running(), .timeout_reset(timeout_reset),
		.wake_request(wake_request), .power_sleep(power_sleep), .power_idle(power_idle));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (timeout_reset === 1'b1) rst_cnt++;
		if (wake_request === 1'b1) wake_cnt++;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		address   <= a;
		write     <= wr;
		read      <= !wr;
		writedata <= d;
		do begin
			@(posedge clk_sys);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task ev(input int k);
		@(posedge clk_sys) evs[k] <= 1'b1;
		@(posedge clk_sys) evs[k] <= 1'b0;
		@(posedge clk_sys);
	endtask : ev

	task ticks(input int n);
		repeat (n) begin
			@(posedge clk_sys) rc <= 1'b1;
			repeat (2) @(posedge clk_sys);
			rc <= 1'b0;
			repeat (2) @(posedge clk_sys);
		end
		repeat (3) @(posedge clk_sys);
	endtask : ticks

	task wrap_up;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	initial begin
		#500us;
		bad_count++;
		wrap_up();
	end

	initial begin
		{rst_n, read, write, fuse, psel, rc, idle_sel, address, post, writedata, evs} = '0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h0);
		chk(32'(rc_clock_enable), 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 4'h0, 32'h20);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h20);
		chk(32'(rc_clock_enable), 32'h1);
		$display("test registers done");
		ticks(31);
		chk(rst_cnt, 0);
		ticks(1);
		chk(rst_cnt, 1);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h30);
		bus(1'b1, 4'h0, 32'h20);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h20);
		$display("test short timeout done");
		psel <= 1'b1;
		post <= 4'h1;
		ev(3);
		ticks(5);
		bus(1'b0, 4'h4, 32'h0);
		chk(q, 32'h0005_0000);
		ev(1);
		bus(1'b0, 4'h4, 32'h0);
		chk(q, 32'h0);
		ticks(100);
		ev(3);
		ticks(255);
		chk(rst_cnt, 1);
		ticks(1);
		chk(rst_cnt, 2);
		$display("test long timeout done");
		psel <= 1'b0;
		post <= 4'h0;
		bus(1'b1, 4'h0, 32'h20);
		ev(3);
		ticks(10);
		ev(2);
		chk(32'(power_sleep), 32'h1);
		ticks(31);
		chk(wake_cnt, 0);
		ticks(1);
		chk(wake_cnt, 1);
		chk(rst_cnt, 2);
		chk(32'(power_sleep), 32'h0);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h38);
		bus(1'b1, 4'h0, 32'h20);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h20);
		idle_sel <= 1'b1;
		ev(2);
		chk(32'(power_idle), 32'h1);
		ev(4);
		chk(32'(power_idle), 32'h0);
		$display("test power states done");
		ev(0);
		chk(32'(rc_clock_enable), 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk(q, 32'h0);
		fuse <= 1'b1;
		bus(1'b1, 4'h0, 32'h0);
		chk(32'(rc_clock_enable), 32'h1);
		ticks(32);
		chk(rst_cnt, 3);
		$display("test hard enable done");
		wrap_up();
	end
endmodule : watchdog_timer_unit_tb

`default_nettype wire
